/* File: include/dmaes_pkg.sv */
package dmaes_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NUM_CH = 6;   // general channels
   localparam int NUM_PORT = 4; // memory-side access ports
   localparam int ADDR_W = 24;  // word address per transfer
   localparam int DATA_W = 16;  // element width
   localparam int IDX_W = 5;    // avalon word index width
   // ----------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [4:0] REG_CTRL0 = 5'h00;  // channel control, one per channel
   localparam logic [4:0] REG_STATUS = 5'h06; // read-only engine state
   localparam logic [4:0] REG_CONFIG = 5'h07; // idle request and serial port modes
   localparam logic [4:0] REG_SRC0 = 5'h08;   // source address + port
   localparam logic [4:0] REG_DST0 = 5'h10;   // destination address + port
   localparam logic [4:0] REG_COUNT0 = 5'h18; // elements left
   // ----------------------------------------
   // channel control fields
   // ----------------------------------------
   localparam int CTRL_DST_MODE_LSB = 14;
   localparam int CTRL_SRC_MODE_LSB = 12;
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_CHANNEL_PRIORITY_BIT = 6;
   localparam int CTRL_SYNC_LSB = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'hFBFF; // bit 10 held at zero
   // ----------------------------------------
   // config and status fields
   // ----------------------------------------
   localparam int CFG_IDLE_BIT = 0;
   localparam int CFG_SP1_LSB = 1;
   localparam int CFG_SP2_LSB = 3;
   localparam logic [4:0] CFG_RESET = 5'h00;
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_IDLE_BIT = 9;
   localparam int STAT_HOST_BIT = 10;
   localparam int STAT_PEND_LSB = 16;
   localparam int PORT_LSB = 24; // port select above the address
   // ----------------------------------------
   // encodings
   // ----------------------------------------
   localparam logic [4:0] SYNC_NONE = 5'h00;
   localparam logic [4:0] SYNC_SP0_RX = 5'h01;
   localparam logic [4:0] SYNC_SP0_TX = 5'h02;
   localparam logic [4:0] SYNC_SP1_RX = 5'h05;
   localparam logic [4:0] SYNC_SP1_TX = 5'h06;
   localparam logic [4:0] SYNC_SP2_RX = 5'h09;
   localparam logic [4:0] SYNC_EXT4_TWI = 5'h13;
   localparam logic [1:0] SP_MODE_BUFFERED = 2'h0;
   localparam logic [1:0] SP_MODE_CARD = 2'h1;
   localparam logic [1:0] AMODE_INC = 2'h1;
   localparam logic [1:0] AMODE_DEC = 2'h2;
   localparam logic [1:0] PORT_DUAL = 2'h0; // 1 single ram, 2 periph, 3 external
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic sp0_rx_event;
      logic sp0_tx_event;
      logic sp1_buffered_rx_event;
      logic sp1_card_rx_event;
      logic sp1_buffered_tx_event;
      logic sp1_card_tx_event;
      logic sp2_buffered_rx_event;
      logic sp2_card_rx_event;
      logic ext_irq_four;
      logic twi_rx_event;
   } dmaes_evt_type;
   typedef struct packed {
      logic req;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dmaes_req_type;
   typedef struct packed {
      logic ack;
      logic [DATA_W-1:0] rdata;
   } dmaes_rsp_type;
   // next address after one element
   function automatic logic [ADDR_W-1:0] amod_next(input logic [ADDR_W-1:0] a,
                                                   input logic [1:0] m);
      if (m == AMODE_INC) begin
         return a + 24'h00_0001;
      end else if (m == AMODE_DEC) begin
         return a - 24'h00_0001;
      end
      return a; // constant, and 11 treated as constant
   endfunction
endpackage

/* File: rtl/_end.sv */
`timescale 1ns/1ns

/* File: rtl/dmaes_ctrl.sv */
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
// Overview of operation
// - six channels, each with own context
// - four ports: dual, single ram, periph, external
// - priority bit 6, low at reset
// - one interrupt output per channel
// - dest mode 15:14, source 13:12, reset 00
// - sync field 4:0 picks event, resets zero
// - ten events, chosen per channel independently
// - code zero runs without event gating
// - codes 1,2: serial port 0 rx, tx
// - code 5: port 1 rx, mode picks source
// - code 6: port 1 tx, mode picks source
// - code 9: port 2 rx, mode picks source
// - serial port codes 5, 6, 9 route only mode-selected peripheral
// - idle domain stops general channels under software
// - dedicated host port channel into dual ram
// - code 13h: ext irq four OR twi rx
module dmaes_ctrl #(
   parameter int CH_COUNT = dmaes_pkg::NUM_CH
) (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic [dmaes_pkg::IDX_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire dmaes_pkg::dmaes_evt_type EVT,
   output dmaes_pkg::dmaes_req_type MEM_REQ [dmaes_pkg::NUM_PORT],
   input wire dmaes_pkg::dmaes_rsp_type MEM_RSP [dmaes_pkg::NUM_PORT],
   input wire dmaes_pkg::dmaes_req_type HOST_REQ,
   output dmaes_pkg::dmaes_rsp_type HOST_RSP,
   output logic [CH_COUNT-1:0] CH_IRQ,
   output logic IDLE_ACK
);
   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   // the address banks leave room for eight channels; control slots 6 and 7 are status and config
   if (CH_COUNT < 1 || CH_COUNT > 8) begin : g_bad
      $error("dmaes_ctrl: CH_COUNT must be 1 to 8");
   end
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1, // arbitrating
      ST_HOST = 4'h2, // host port access on dual ram
      ST_READ = 4'h4, // fetching source element
      ST_WRITE = 4'h8 // storing to destination
   } dmaes_state_type;
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [15:0] ctrl_q [CH_COUNT]; // channel control
   logic [15:0] ctrl_d [CH_COUNT];
   logic [25:0] src_q [CH_COUNT];  // port + source address
   logic [25:0] src_d [CH_COUNT];
   logic [25:0] dst_q [CH_COUNT];  // port + destination address
   logic [25:0] dst_d [CH_COUNT];
   logic [15:0] cnt_q [CH_COUNT];  // elements left
   logic [15:0] cnt_d [CH_COUNT];
   logic [4:0] cfg_q;              // idle request, serial port modes
   logic [4:0] cfg_d;
   dmaes_state_type st_q;
   dmaes_state_type st_d;
   logic [2:0] cur_q;              // channel in flight
   logic [2:0] cur_d;
   logic [15:0] data_q;            // element between read and write
   logic [15:0] data_d;
   dmaes_pkg::dmaes_req_type req_q [dmaes_pkg::NUM_PORT];
   dmaes_pkg::dmaes_req_type req_d [dmaes_pkg::NUM_PORT];
   dmaes_pkg::dmaes_rsp_type hrsp_q;
   dmaes_pkg::dmaes_rsp_type hrsp_d;
   logic [CH_COUNT-1:0] irq_q;
   logic [CH_COUNT-1:0] irq_d;
   logic idle_q;
   logic idle_d;
   logic wait_q;                   // avalon waitrequest
   logic wait_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic [CH_COUNT-1:0] pending;   // sync condition met
   logic [CH_COUNT-1:0] consume;   // channel served this cycle
   logic [CH_COUNT-1:0] ready;
   logic [CH_COUNT-1:0] hi_channel_priority;
   logic bus_wr;                   // write handshake edge
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // high priority first, then lowest index
   function automatic logic [2:0] pick(input logic [CH_COUNT-1:0] rdy,
                                       input logic [CH_COUNT-1:0] hi);
      logic [2:0] s;
      logic fnd;
      s = 3'h0;
      fnd = 1'h0;
      for (int c = 0; c < CH_COUNT; c++) begin
         if (!fnd && rdy[c] && hi[c]) begin
            s = 3'(c);
            fnd = 1'h1;
         end
      end
      for (int c = 0; c < CH_COUNT; c++) begin
         if (!fnd && rdy[c]) begin
            s = 3'(c);
            fnd = 1'h1;
         end
      end
      return s;
   endfunction
   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction
   // request word for one element access
   function automatic dmaes_pkg::dmaes_req_type mk_req(input logic we, input logic [25:0] a,
                                                       input logic [15:0] wd);
      dmaes_pkg::dmaes_req_type r;
      r.req = 1'h1;
      r.we = we;
      r.addr = a[dmaes_pkg::ADDR_W-1:0];
      r.wdata = wd;
      return r;
   endfunction
   // ----------------------------------------
   // per-channel event selection
   // ----------------------------------------
   // each channel owns its selector, so bindings are independent
   for (genvar c = 0; c < CH_COUNT; c++) begin : g_sync
      dmaes_sync u_sync (
         .clk(MCLK),
         .rst_n(NRST),
         .code(ctrl_q[c][dmaes_pkg::CTRL_SYNC_LSB +: 5]),
         .evt(EVT),
         .sp1_mode(cfg_q[dmaes_pkg::CFG_SP1_LSB +: 2]),
         .sp2_mode(cfg_q[dmaes_pkg::CFG_SP2_LSB +: 2]),
         .consume(consume[c]),
         .pending(pending[c])
      );
      // disabled channels never compete
      assign ready[c] = ctrl_q[c][dmaes_pkg::CTRL_EN_BIT] & (cnt_q[c] != 16'h0000) & pending[c];
      assign hi_channel_priority[c] = ctrl_q[c][dmaes_pkg::CTRL_CHANNEL_PRIORITY_BIT];
   end
   assign bus_wr = AVS_WRITE & ~wait_q;
   // ----------------------------------------
   // engine and register next state
   // ----------------------------------------
   always_comb begin
      logic [1:0] sp;
      logic [1:0] dp;
      logic [31:0] w;
      st_d = st_q;
      cur_d = cur_q;
      data_d = data_q;
      req_d = req_q;
      hrsp_d = '0;
      irq_d = '0;
      consume = '0;
      ctrl_d = ctrl_q;
      src_d = src_q;
      dst_d = dst_q;
      cnt_d = cnt_q;
      cfg_d = cfg_q;
      sp = src_q[cur_q][dmaes_pkg::PORT_LSB +: 2];
      dp = dst_q[cur_q][dmaes_pkg::PORT_LSB +: 2];
      w = 32'h0000_0000;
      unique case (st_q)
         ST_IDLE: begin
            // a request whose answer is showing is the one just served
            if (HOST_REQ.req && !hrsp_q.ack) begin
               // the host channel bypasses the general channels
               req_d[dmaes_pkg::PORT_DUAL] = HOST_REQ;
               st_d = ST_HOST;
            end else if (!cfg_q[dmaes_pkg::CFG_IDLE_BIT] && (|ready)) begin
               cur_d = pick(ready, hi_channel_priority);
               consume[cur_d] = 1'h1;
               req_d[src_q[cur_d][dmaes_pkg::PORT_LSB +: 2]] = mk_req(1'h0, src_q[cur_d],
                                                                      16'h0000);
               st_d = ST_READ;
            end
         end
         ST_HOST: begin
            if (MEM_RSP[dmaes_pkg::PORT_DUAL].ack) begin
               req_d[dmaes_pkg::PORT_DUAL] = '0;
               hrsp_d = '{ack: 1'h1, rdata: MEM_RSP[dmaes_pkg::PORT_DUAL].rdata};
               st_d = ST_IDLE;
            end
         end
         ST_READ: begin
            if (MEM_RSP[sp].ack) begin
               // clear before set: source and destination may share a port
               req_d[sp] = '0;
               data_d = MEM_RSP[sp].rdata;
               req_d[dp] = mk_req(1'h1, dst_q[cur_q], MEM_RSP[sp].rdata);
               st_d = ST_READ == st_q ? ST_WRITE : st_q;
            end
         end
         ST_WRITE: begin
            if (MEM_RSP[dp].ack) begin
               req_d[dp] = '0;
               // only the served channel's context moves
               src_d[cur_q][23:0] = dmaes_pkg::amod_next(src_q[cur_q][23:0],
                  ctrl_q[cur_q][dmaes_pkg::CTRL_SRC_MODE_LSB +: 2]);
               dst_d[cur_q][23:0] = dmaes_pkg::amod_next(dst_q[cur_q][23:0],
                  ctrl_q[cur_q][dmaes_pkg::CTRL_DST_MODE_LSB +: 2]);
               cnt_d[cur_q] = cnt_q[cur_q] - 16'h0001;
               if (cnt_q[cur_q] == 16'h0001) begin
                  irq_d[cur_q] = 1'h1; // block done
                  ctrl_d[cur_q][dmaes_pkg::CTRL_EN_BIT] = 1'h0;
               end
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      // software writes land last, so they win over engine updates
      if (bus_wr) begin
         for (int c = 0; c < CH_COUNT; c++) begin
            if (AVS_ADDRESS == 5'(dmaes_pkg::REG_CTRL0 + c)) begin
               w = merge({16'h0000, ctrl_q[c]}, AVS_WRITEDATA, AVS_BYTEENABLE);
               ctrl_d[c] = w[15:0] & dmaes_pkg::CTRL_WMASK;
            end
            if (AVS_ADDRESS == 5'(dmaes_pkg::REG_SRC0 + c)) begin
               w = merge({6'h00, src_q[c]}, AVS_WRITEDATA, AVS_BYTEENABLE);
               src_d[c] = w[25:0];
            end
            if (AVS_ADDRESS == 5'(dmaes_pkg::REG_DST0 + c)) begin
               w = merge({6'h00, dst_q[c]}, AVS_WRITEDATA, AVS_BYTEENABLE);
               dst_d[c] = w[25:0];
            end
            if (AVS_ADDRESS == 5'(dmaes_pkg::REG_COUNT0 + c)) begin
               w = merge({16'h0000, cnt_q[c]}, AVS_WRITEDATA, AVS_BYTEENABLE);
               cnt_d[c] = w[15:0];
            end
         end
         if (AVS_ADDRESS == dmaes_pkg::REG_CONFIG) begin
            w = merge({27'h000_0000, cfg_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
            cfg_d = w[4:0];
         end
      end
   end
   // ----------------------------------------
   // avalon slave: one wait state, then answer
   // ----------------------------------------
   always_comb begin
      wait_d = 1'h1;
      rdat_d = rdat_q;
      // a request is answered once; back-to-back requests restart here
      if ((AVS_READ || AVS_WRITE) && wait_q) begin
         wait_d = 1'h0;
         rdat_d = 32'h0000_0000; // unmapped reads return zero
         for (int c = 0; c < CH_COUNT; c++) begin
            if (AVS_ADDRESS == 5'(dmaes_pkg::REG_CTRL0 + c)) begin
               rdat_d = {16'h0000, ctrl_q[c]};
            end
            if (AVS_ADDRESS == 5'(dmaes_pkg::REG_SRC0 + c)) begin
               rdat_d = {6'h00, src_q[c]};
            end
            if (AVS_ADDRESS == 5'(dmaes_pkg::REG_DST0 + c)) begin
               rdat_d = {6'h00, dst_q[c]};
            end
            if (AVS_ADDRESS == 5'(dmaes_pkg::REG_COUNT0 + c)) begin
               rdat_d = {16'h0000, cnt_q[c]};
            end
            if (AVS_ADDRESS == dmaes_pkg::REG_STATUS) begin
               rdat_d[c] = ctrl_q[c][dmaes_pkg::CTRL_EN_BIT];
               rdat_d[dmaes_pkg::STAT_PEND_LSB + c] = pending[c];
            end
         end
         if (AVS_ADDRESS == dmaes_pkg::REG_STATUS) begin
            rdat_d[dmaes_pkg::STAT_BUSY_BIT] = (st_q != ST_IDLE);
            rdat_d[dmaes_pkg::STAT_IDLE_BIT] = idle_q;
            rdat_d[dmaes_pkg::STAT_HOST_BIT] = (st_q == ST_HOST);
         end
         if (AVS_ADDRESS == dmaes_pkg::REG_CONFIG) begin
            rdat_d = {27'h000_0000, cfg_q};
         end
      end
      // idle acknowledged once nothing is in flight
      idle_d = cfg_q[dmaes_pkg::CFG_IDLE_BIT] & (st_q == ST_IDLE);
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         for (int c = 0; c < CH_COUNT; c++) begin
            ctrl_q[c] <= dmaes_pkg::CTRL_RESET;
            src_q[c] <= '0;
            dst_q[c] <= '0;
            cnt_q[c] <= '0;
         end
         for (int p = 0; p < dmaes_pkg::NUM_PORT; p++) begin
            req_q[p] <= '0;
         end
         cfg_q <= dmaes_pkg::CFG_RESET;
         st_q <= ST_IDLE;
         cur_q <= 3'h0;
         data_q <= 16'h0000;
         hrsp_q <= '0;
         irq_q <= '0;
         idle_q <= 1'h0;
         wait_q <= 1'h1;
         rdat_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         src_q <= src_d;
         dst_q <= dst_d;
         cnt_q <= cnt_d;
         req_q <= req_d;
         cfg_q <= cfg_d;
         st_q <= st_d;
         cur_q <= cur_d;
         data_q <= data_d;
         hrsp_q <= hrsp_d;
         irq_q <= irq_d;
         idle_q <= idle_d;
         wait_q <= wait_d;
         rdat_q <= rdat_d;
      end
   end
   // ----------------------------------------
   // outputs, all from flops
   // ----------------------------------------
   assign AVS_READDATA = rdat_q;
   assign AVS_WAITREQUEST = wait_q;
   assign MEM_REQ = req_q;
   assign HOST_RSP = hrsp_q;
   assign CH_IRQ = irq_q;
   assign IDLE_ACK = idle_q;
endmodule

/* File: rtl/dmaes_sync.sv */
`timescale 1ns/1ns
// per-channel event selector with a sticky pending flag
module dmaes_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] code,
   input wire dmaes_pkg::dmaes_evt_type evt,
   input wire logic [1:0] sp1_mode,
   input wire logic [1:0] sp2_mode,
   input wire logic consume,
   output logic pending
);
   logic hit;    // selected event this cycle
   logic pend_q; // event seen, not yet served
   logic pend_d;
   // ----------------------------------------
   // event multiplexer
   // ----------------------------------------
   always_comb begin
      hit = 1'h0; // reserved codes never fire
      unique case (code)
         dmaes_pkg::SYNC_SP0_RX: hit = evt.sp0_rx_event;
         dmaes_pkg::SYNC_SP0_TX: hit = evt.sp0_tx_event;
         dmaes_pkg::SYNC_SP1_RX: begin
            // only the peripheral the mode selects reaches the channel
            if (sp1_mode == dmaes_pkg::SP_MODE_BUFFERED) begin
               hit = evt.sp1_buffered_rx_event;
            end else if (sp1_mode == dmaes_pkg::SP_MODE_CARD) begin
               hit = evt.sp1_card_rx_event;
            end
         end
         dmaes_pkg::SYNC_SP1_TX: begin
            if (sp1_mode == dmaes_pkg::SP_MODE_BUFFERED) begin
               hit = evt.sp1_buffered_tx_event;
            end else if (sp1_mode == dmaes_pkg::SP_MODE_CARD) begin
               hit = evt.sp1_card_tx_event;
            end
         end
         dmaes_pkg::SYNC_SP2_RX: begin
            if (sp2_mode == dmaes_pkg::SP_MODE_BUFFERED) begin
               hit = evt.sp2_buffered_rx_event;
            end else if (sp2_mode == dmaes_pkg::SP_MODE_CARD) begin
               hit = evt.sp2_card_rx_event;
            end
         end
         // two sources share one sync input
         dmaes_pkg::SYNC_EXT4_TWI: hit = evt.ext_irq_four | evt.twi_rx_event;
         default: hit = 1'h0;
      endcase
      // a new event in the serving cycle is kept
      pend_d = hit | (pend_q & ~consume);
   end
   // ----------------------------------------
   // pending flag
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'h0;
      end else begin
         pend_q <= pend_d;
      end
   end
   // unsynchronised channels always show pending
   assign pending = (code == dmaes_pkg::SYNC_NONE) | pend_q;
endmodule

/* File: tb/dma_channel_event_sync_bench.sv */
`timescale 1ns/1ns
module dma_channel_event_sync_bench;
   // ----
   // pins and bookkeeping
   // ----
   logic MCLK = 1'b0;
   logic NRST = 1'b0;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdata;
   logic wreq;
   logic [9:0] evt = 10'h000; // msb is port 0 receive
   dmaes_pkg::dmaes_req_type host = '0;
   dmaes_pkg::dmaes_req_type mreq [dmaes_pkg::NUM_PORT];
   dmaes_pkg::dmaes_rsp_type mrsp [dmaes_pkg::NUM_PORT];
   dmaes_pkg::dmaes_rsp_type hrsp;
   logic [5:0] irq;
   logic idle_ack;
   logic [31:0] rd_q [$]; // expected read data
   logic [31:0] irq_q [$]; // expected interrupting channel
   int miscompares = 0;
   int check_count = 0;
   logic [31:0] seed = 32'h0000_F212;
   int i;
   logic [4:0] ch;
   logic [19:0] t;
   logic [31:0] v [6];
   logic [31:0] a;
   // code, config, wanted event, other event; reserved codes left out
   logic [19:0] tbl [10] = '{20'h0_1098, 20'h0_2089, 20'h0_5076, 20'h0_5267, 20'h0_6054,
      20'h0_6245, 20'h0_9032, 20'h0_9823, 20'h1_3019, 20'h1_3008};
   always #2 MCLK = ~MCLK;
   dmaes_ctrl dut_u (.MCLK(MCLK), .NRST(NRST), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .EVT(dmaes_pkg::dmaes_evt_type'(evt)), .MEM_REQ(mreq),
      .MEM_RSP(mrsp), .HOST_REQ(host), .HOST_RSP(hrsp), .CH_IRQ(irq), .IDLE_ACK(idle_ack));
   dmaes_mem_model mem_u (.MCLK(MCLK), .NRST(NRST), .req(mreq), .rsp(mrsp));
   // ----
   // helpers
   // ----
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      if (miscompares == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // request held until waitrequest is sampled low
   task bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
      @(posedge MCLK);
      adr <= ad;
      rd <= !w;
      wr <= w;
      wd <= d;
      do @(posedge MCLK); while (wreq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task rdx(input logic [4:0] ad, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, ad, 32'h0000_0000);
   endtask
   task pulse(input logic [3:0] b);
      @(posedge MCLK);
      evt[b] <= 1'b1;
      @(posedge MCLK);
      evt[b] <= 1'b0;
   endtask
   task drain;
      int n;
      n = 0;
      while (irq_q.size() != 0 && n < 400) begin
         @(posedge MCLK);
         n++;
      end
      check(irq_q.size(), 32'h0000_0000);
   endtask
   // ----
   // result watcher: oldest note against each answer
   // ----
   always @(posedge MCLK) begin
      if (rd === 1'b1 && wreq === 1'b0) check(rdata, rd_q.pop_front());
      // only the last two channels write port 1: source 0x100 on dual ram, dest 0x200
      if (mreq[1].req === 1'b1 && mrsp[1].ack === 1'b1)
         check({mreq[1].addr[15:0], mreq[1].wdata}, 32'h0200_A4A5);
      for (int c = 0; c < 6; c++) begin
         if (irq[c] === 1'b1)
            check(c, irq_q.size() > 0 ? irq_q.pop_front() : 32'h0000_DEAD);
      end
   end
   initial begin
      repeat (20000) @(posedge MCLK);
      miscompares++;
      conclude();
   end
   // ----
   // main sequence
   // ----
   initial begin
      repeat (10) @(posedge MCLK);
      NRST <= 1'b1;
      for (i = 0; i < 8; i++) begin
         if (i != 6) rdx(5'(i), 32'h0000_0000);
      end
      rdx(5'h1F, 32'h0000_0000);
      for (i = 0; i < 6; i++) begin
         v[i] = (rnd() & 32'h0000_FF40) | 32'h0000_0400;
         bus(1'b1, 5'(i), v[i]);
      end
      for (i = 0; i < 6; i++) rdx(5'(i), v[i] & 32'h0000_FBFF);
      for (i = 0; i < 10; i++) begin
         t = tbl[i];
         ch = 5'(i % 6);
         bus(1'b1, 5'h08 + ch, 32'h0200_1000 + i);
         bus(1'b1, 5'h10 + ch, 32'h0300_2000);
         // sync code goes in before the count, so an old enable cannot start early
         bus(1'b1, 5'h07, {28'h000_0000, t[11:8]});
         bus(1'b1, ch, {16'h0000, 8'h90, 3'h4, t[16:12]});
         bus(1'b1, 5'h18 + ch, 32'h0000_0001);
         pulse(t[3:0]);
         repeat (20) @(posedge MCLK);
         irq_q.push_back(32'(ch));
         pulse(t[7:4]);
         drain();
         rdx(5'h08 + ch, 32'h0200_1001 + i);
         rdx(5'h10 + ch, 32'h0300_1FFF);
         rdx(ch, {16'h0000, 8'h90, 3'h0, t[16:12]});
         bus(1'b1, ch, 32'h0000_0000);
      end
      bus(1'b1, 5'h07, 32'h0000_0001);
      repeat (5) @(posedge MCLK);
      check(idle_ack, 1'b1);
      a = rnd();
      @(posedge MCLK);
      host <= '{1'b1, 1'b0, a[23:0], 16'h0000};
      do @(posedge MCLK); while (hrsp.ack !== 1'b1);
      check(hrsp.rdata, a[15:0] ^ 16'hA5A5);
      host.req <= 1'b0;
      for (i = 4; i < 6; i++) begin
         bus(1'b1, 5'(8 + i), 32'h0000_0100);
         bus(1'b1, 5'(16 + i), 32'h0100_0200);
         bus(1'b1, 5'(24 + i), 32'h0000_0001);
         bus(1'b1, 5'(i), {24'h00_0000, 1'b1, i == 5, 6'h00});
      end
      repeat (20) @(posedge MCLK);
      irq_q.push_back(32'h0000_0005);
      irq_q.push_back(32'h0000_0004);
      bus(1'b1, 5'h07, 32'h0000_0000);
      drain();
      conclude();
   end
endmodule

/* File: tb/dmaes_ctrl_asserts.sv */
`timescale 1ns/1ns
// ----
// port-level checks of the channel controller
// ----
module dmaes_ctrl_asserts #(
   parameter int CH_COUNT = dmaes_pkg::NUM_CH
) (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic [dmaes_pkg::IDX_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire dmaes_pkg::dmaes_req_type MEM_REQ [dmaes_pkg::NUM_PORT],
   input wire dmaes_pkg::dmaes_rsp_type MEM_RSP [dmaes_pkg::NUM_PORT],
   input wire dmaes_pkg::dmaes_rsp_type HOST_RSP,
   input wire logic [CH_COUNT-1:0] CH_IRQ,
   input wire logic IDLE_ACK
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   // request seen by the slave but not yet answered
   sequence s_taken;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence s_ctrl_read;
      AVS_READ && AVS_WAITREQUEST && (AVS_ADDRESS < 5'h06);
   endsequence
   // three cycles of ack covers the one-cycle lag of the registered flag
   sequence s_idle_held;
      IDLE_ACK [*3];
   endsequence
   chk_wait_one: assert property (s_taken |=> !AVS_WAITREQUEST)
      else $error("waitrequest not low one cycle after request");
   chk_wait_rest: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");
   chk_bit10_zero: assert property (s_ctrl_read |=> AVS_READDATA[10] == 1'b0)
      else $error("reserved control bit read as one");
   chk_irq_pulse: assert property ((CH_IRQ != '0) |->
      $onehot(CH_IRQ) ##1 (CH_IRQ == '0))
      else $error("channel interrupt not a single one-cycle pulse");
   chk_req_hold: assert property (MEM_REQ[1].req && !MEM_RSP[1].ack |=>
      MEM_REQ[1].req && $stable(MEM_REQ[1].addr)) else $error("port request dropped before ack");
   chk_req_drop: assert property (MEM_REQ[2].req && MEM_RSP[2].ack |=> !MEM_REQ[2].req)
      else $error("port request kept after ack");
   chk_host_pulse: assert property (HOST_RSP.ack |=> !HOST_RSP.ack)
      else $error("host answer longer than one cycle");
   chk_idle_quiet: assert property (s_idle_held |-> !MEM_REQ[1].req
      && !MEM_REQ[2].req && !MEM_REQ[3].req) else $error("general transfer while idle");
endmodule
bind dmaes_ctrl dmaes_ctrl_asserts #(.CH_COUNT(CH_COUNT)) chk_u (.MCLK(MCLK), .NRST(NRST),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .MEM_REQ(MEM_REQ),
   .MEM_RSP(MEM_RSP), .HOST_RSP(HOST_RSP), .CH_IRQ(CH_IRQ), .IDLE_ACK(IDLE_ACK));

/* File: tb/dmaes_mem_model.sv */
`timescale 1ns/1ns
// ----
// four memory ports answering after 0..3 wait cycles
// ----
module dmaes_mem_model (
   input wire logic MCLK,
   input wire logic NRST,
   input wire dmaes_pkg::dmaes_req_type req [dmaes_pkg::NUM_PORT],
   output dmaes_pkg::dmaes_rsp_type rsp [dmaes_pkg::NUM_PORT]
);
   logic [1:0] wait_q [dmaes_pkg::NUM_PORT]; // cycles left before ack
   logic [7:0] lfsr_q; // varies the latency
   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         lfsr_q <= 8'h5B;
         for (int p = 0; p < dmaes_pkg::NUM_PORT; p++) begin
            rsp[p] <= '0;
            wait_q[p] <= 2'h0;
         end
      end else begin
         lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
         for (int p = 0; p < dmaes_pkg::NUM_PORT; p++) begin
            rsp[p].ack <= 1'b0;
            // data outside the ack cycle is junk, so a late sample shows up
            rsp[p].rdata <= ~rsp[p].rdata;
            if (req[p].req && !rsp[p].ack) begin
               if (wait_q[p] == 2'h0) begin
                  rsp[p].ack <= 1'b1;
                  rsp[p].rdata <= req[p].addr[15:0] ^ 16'hA5A5;
                  wait_q[p] <= lfsr_q[1:0];
               end else begin
                  wait_q[p] <= wait_q[p] - 2'h1;
               end
            end
         end
      end
   end
endmodule
